//--- design/sbr_consts.svh
// Constants for the SDRAM bank, refresh and init controller
// What this block does
// - Noncached access within bus width: one command
// - Row hold uses commands without auto close
// - Row hold: same row skips row open
// - Each bank tracks its own open row
// - Row miss: close bank, wait, open, access
// - Write auto close: recovery plus close wait
// - Same row read at latency one: idle first
// - Any refresh marks all banks closed
// - Mode and enable bits choose auto or self
// - Selected clock: counter counts from current value
// - Counter match: request, repeat refreshes, clear counter
// - Auto refresh: close all, wait, refresh, recover
// - Close wait cycle when close wait two plus
// - Self entry: close all, wait, enter, no access
// - Clearing mode ends self, then recovery wait
// - Self refresh persists; reset clears it
// - Refresh waits for running bus cycle
// - Newer request replaces older pending one
// - Mode window write drives offset on address
// - Mode load: close, eight refreshes, load, idle
// - Burst length one, wide transfers split
// - Latency setting gives one to four cycles
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH
`define SBR_REG_PAGE 24'hF8FC00
`define SBR_MODE_PAGE 20'hF8FD5
`define SBR_OFF_CTRL 8'h00
`define SBR_OFF_TCTL 8'h04
`define SBR_OFF_COR 8'h08
`define SBR_OFF_CNT 8'h0C
`define SBR_OFF_WAIT 8'h10
`define SBR_OFF_STAT 8'h14
`define SBR_CTRL_HOLD 0
`define SBR_CTRL_MODE 1
`define SBR_CTRL_EN 2
`define SBR_CTRL_RST 3'h0
`define SBR_TCTL_RST 7'h00
`define SBR_WAIT_RST 8'h00
`define SBR_INIT_REFS 4'h8
`define SBR_AP_BIT 10
`define SBR_CMD_NOP 4'h7
`define SBR_CMD_ACT 4'h3
`define SBR_CMD_RD 4'h5
`define SBR_CMD_WR 4'h4
`define SBR_CMD_PRE 4'h2
`define SBR_CMD_REF 4'h1
`define SBR_CMD_MRS 4'h0
`endif

//--- design/sbr_pkg.sv
// Types shared by the SDRAM controller modules
package sbr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PRE = 4'h1, ST_PWAIT = 4'h2, ST_OPEN = 4'h3,
    ST_NOP = 4'h4, ST_CMD = 4'h5, ST_GAP = 4'h6, ST_RDW = 4'h7,
    ST_APW = 4'h8, ST_ALL_BANK_CLOSE_CMD = 4'h9, ST_PALLW = 4'hA, ST_REF = 4'hB,
    ST_RECW = 4'hC, ST_SELF = 4'hD, ST_MRS = 4'hE
  } sbr_state_t;
  typedef enum logic [1:0] {
    JOB_AUTO = 2'h0, JOB_SELF = 2'h1, JOB_INIT = 2'h2
  } sbr_job_t;
endpackage

//--- design/sbr_if.sv
// Links the controller with its bank table and refresh timer
`timescale 1ns/10ps
interface sbr_if #(parameter int NB = 4, parameter int RW = 13,
  parameter int TW = 8);
  logic [$clog2(NB)-1:0] bt_bank;
  logic [RW-1:0] bt_row;
  logic bt_set, bt_close, bt_close_all, bt_open, bt_hit;
  logic [2:0] refresh_clock_select;
  logic [TW-1:0] cor, cnt, cnt_wdata;
  logic cnt_wr, ref_ok, ref_take, ref_pend;
  modport ctrl (output bt_bank, bt_row, bt_set, bt_close, bt_close_all,
    refresh_clock_select, cor, cnt_wdata, cnt_wr, ref_ok, ref_take,
    input bt_open, bt_hit, cnt, ref_pend);
  modport bank (input bt_bank, bt_row, bt_set, bt_close, bt_close_all,
    output bt_open, bt_hit);
  modport tmr (input refresh_clock_select, cor, cnt_wdata, cnt_wr, ref_ok, ref_take,
    output cnt, ref_pend);
endinterface

//--- design/sbr_bank_table.sv
// Open row table, one entry per SDRAM bank
`timescale 1ns/10ps
module sbr_bank_table
  import sbr_pkg::*;
#(parameter int NB = 4, parameter int RW = 13)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Controller side
  sbr_if.bank bif
);
  logic [NB-1:0] open_r, open_nxt;
  logic [RW-1:0] row_r [NB];
  logic [RW-1:0] row_nxt [NB];
  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      always_comb
      begin
        open_nxt[g] = open_r[g];
        row_nxt[g] = row_r[g];
        if (bif.bt_close_all)
          open_nxt[g] = 1'b0;
        else if (bif.bt_bank == g && bif.bt_close)
          open_nxt[g] = 1'b0;
        else if (bif.bt_bank == g && bif.bt_set)
        begin
          open_nxt[g] = 1'b1;
          row_nxt[g] = bif.bt_row;
        end
      end
      always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
          open_r[g] <= 1'b0;
          row_r[g] <= '0;
        end
        else
        begin
          open_r[g] <= open_nxt[g];
          row_r[g] <= row_nxt[g];
        end
    end
  endgenerate
  assign bif.bt_open = open_r[bif.bt_bank];
  assign bif.bt_hit = row_r[bif.bt_bank] == bif.bt_row;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  close_all_a: assert property (bif.bt_close_all |=> open_r == '0)
    else $error("bank left open after close all");
endmodule

//--- design/sbr_refresh_timer.sv
// Refresh interval counter, compare and pending request
`timescale 1ns/10ps
module sbr_refresh_timer
  import sbr_pkg::*;
#(parameter int TW = 8)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Controller side
  sbr_if.tmr tif
);
  logic [15:0] div_r, div_nxt, mask;
  logic [TW-1:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt, tick, match;
  always_comb
  begin
    case (tif.refresh_clock_select)
      3'h1: mask = 16'h0003;
      3'h2: mask = 16'h000F;
      3'h3: mask = 16'h003F;
      3'h4: mask = 16'h00FF;
      3'h5: mask = 16'h03FF;
      3'h6: mask = 16'h0FFF;
      3'h7: mask = 16'h3FFF;
      default: mask = 16'h0000;
    endcase
    div_nxt = (tif.refresh_clock_select == 3'h0) ? 16'h0000 : div_r + 16'h0001;
    tick = (tif.refresh_clock_select != 3'h0) && ((div_r & mask) == mask);
    match = tick && (cnt_r == tif.cor);
    cnt_nxt = cnt_r;
    if (tif.cnt_wr)
      cnt_nxt = tif.cnt_wdata;
    else if (match)
      cnt_nxt = '0;
    else if (tick)
      cnt_nxt = cnt_r + 1'b1;
    // Only one request is kept; a new match stands in for an old one
    pend_nxt = tif.ref_ok && ((match) || (pend_r && !tif.ref_take));
  end
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      div_r <= 16'h0000;
      cnt_r <= '0;
      pend_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  assign tif.cnt = cnt_r;
  assign tif.ref_pend = pend_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  match_clear_a: assert property (match && !tif.cnt_wr |=> cnt_r == '0)
    else $error("counter not cleared on match");
  ref_off_a: assert property (!tif.ref_ok |=> !pend_r)
    else $error("request pending while refresh disabled");
  match_req_a: assert property (match && tif.ref_ok |=> pend_r)
    else $error("match raised no request");
endmodule

//--- design/sbr_ctrl.sv
// SDRAM controller top: accesses, refresh, self refresh, mode load
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "sbr_consts.svh"
module sbr_ctrl
  import sbr_pkg::*;
#(
  parameter int NB = 4,
  parameter int RW = 13,
  parameter int CW = 10,
  parameter int DW = 32,
  parameter int TW = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  // Access port from the bus masters
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic acc_cacheable,
  input wire logic [1:0] acc_size,
  input wire logic [$clog2(NB)-1:0] acc_bank,
  input wire logic [RW-1:0] acc_row,
  input wire logic [CW-1:0] acc_col,
  input wire logic [DW-1:0] acc_wdata,
  input wire logic [DW/8-1:0] acc_be,
  output logic acc_ack_r,
  output logic acc_rvalid_r,
  output logic [DW-1:0] acc_rdata_r,
  // SDRAM pins
  output logic [3:0] sd_cmd_n_r,
  output logic sd_cke_r,
  output logic [$clog2(NB)-1:0] sd_ba_r,
  output logic [RW-1:0] sd_addr_r,
  output logic [DW/8-1:0] sd_dqm_r,
  output logic [DW-1:0] sd_dq_out_r,
  output logic sd_dq_oe_r,
  input wire logic [DW-1:0] sd_dq_in
);
  localparam logic [4:0] BPW = 5'(DW / 8);
  sbr_if #(.NB(NB), .RW(RW), .TW(TW)) lnk ();
  sbr_bank_table #(.NB(NB), .RW(RW)) u_bank (
    .mclk(mclk),
    .nrst(nrst),
    .bif(lnk.bank)
  );
  sbr_refresh_timer #(.TW(TW)) u_tmr (
    .mclk(mclk),
    .nrst(nrst),
    .tif(lnk.tmr)
  );

  logic [2:0] ctrl_r, ctrl_nxt;
  logic [6:0] tctl_r, tctl_nxt;
  logic [TW-1:0] cor_r, cor_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic [31:0] rdata_nxt;
  logic reg_page, mode_hit, mset, mtake, mpend_r, mpend_nxt;
  logic [11:0] mval_r, mval_nxt;
  logic hold, self_want;

  assign reg_page = reg_addr[31:8] == `SBR_REG_PAGE;
  assign mode_hit = reg_wr && reg_addr[31:12] == `SBR_MODE_PAGE;
  assign hold = ctrl_r[`SBR_CTRL_HOLD];
  assign self_want = ctrl_r[`SBR_CTRL_MODE] && ctrl_r[`SBR_CTRL_EN];
  assign lnk.refresh_clock_select = tctl_r[2:0];
  assign lnk.cor = cor_r;
  assign lnk.cnt_wdata = reg_wdata[TW-1:0];
  assign lnk.cnt_wr = reg_wr && reg_page && reg_addr[7:0] == `SBR_OFF_CNT;
  assign lnk.ref_ok = ctrl_r[`SBR_CTRL_EN]
    && !ctrl_r[`SBR_CTRL_MODE];

  sbr_state_t state_r, state_nxt;
  sbr_job_t job_r, job_nxt;
  logic [2:0] wcnt_r, wcnt_nxt;
  logic [3:0] left_r, left_nxt, beat_r, beat_nxt, nbeats, ibeat;
  logic [3:0] cmd_nxt;
  logic cke_nxt, oe_nxt, ack_nxt, last_r, last_nxt;
  logic [$clog2(NB)-1:0] ba_nxt;
  logic [RW-1:0] addr_nxt;
  logic [DW/8-1:0] dqm_nxt;
  logic [DW-1:0] dout_nxt;
  logic go_cmd, go_open, go_all_bank_close_cmd, post_all_bank_close_cmd, go_ref, ilast;
  logic rd_issue, bt_set, bt_close, bt_close_all, ref_take;
  logic [4:0] acc_bytes;
  logic [2:0] pwc, apw;
  logic pw2;
  logic [1:0] cl;
  logic [3:0] pv_r, pv_nxt, pl_r, pl_nxt;
  logic rv_nxt;
  logic [DW-1:0] rdat_nxt;

  assign lnk.bt_bank = acc_bank;
  assign lnk.bt_row = acc_row;
  assign lnk.bt_set = bt_set;
  assign lnk.bt_close = bt_close;
  assign lnk.bt_close_all = bt_close_all;
  assign lnk.ref_take = ref_take;
  assign cl = wait_r[5:4];
  assign pw2 = wait_r[1:0] >= 2'h2;
  assign pwc = {1'b0, wait_r[1:0]} - 3'h2;

  // Register file and mode window
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    tctl_nxt = tctl_r;
    cor_nxt = cor_r;
    wait_nxt = wait_r;
    rdata_nxt = 32'h0000_0000;
    mset = mode_hit;
    mval_nxt = mode_hit ? reg_addr[11:0] : mval_r;
    mpend_nxt = mset || (mpend_r && !mtake);
    if (reg_wr && reg_page)
      case (reg_addr[7:0])
        `SBR_OFF_CTRL: ctrl_nxt = reg_wdata[2:0];
        `SBR_OFF_TCTL: tctl_nxt = reg_wdata[6:0];
        `SBR_OFF_COR: cor_nxt = reg_wdata[TW-1:0];
        `SBR_OFF_WAIT: wait_nxt = reg_wdata[7:0];
        default: ;
      endcase
    if (reg_rd && reg_page)
      case (reg_addr[7:0])
        `SBR_OFF_CTRL: rdata_nxt = 32'(ctrl_r);
        `SBR_OFF_TCTL: rdata_nxt = 32'(tctl_r);
        `SBR_OFF_COR: rdata_nxt = 32'(cor_r);
        `SBR_OFF_CNT: rdata_nxt = 32'(lnk.cnt);
        `SBR_OFF_WAIT: rdata_nxt = 32'(wait_r);
        `SBR_OFF_STAT: rdata_nxt = 32'({mpend_r, state_r != ST_IDLE,
          lnk.ref_pend, state_r == ST_SELF});
        default: rdata_nxt = 32'h0000_0000;
      endcase
  end
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      ctrl_r <= `SBR_CTRL_RST;
      tctl_r <= `SBR_TCTL_RST;
      cor_r <= '0;
      wait_r <= `SBR_WAIT_RST;
      reg_rdata_r <= 32'h0000_0000;
      mpend_r <= 1'b0;
      mval_r <= 12'h000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      tctl_r <= tctl_nxt;
      cor_r <= cor_nxt;
      wait_r <= wait_nxt;
      reg_rdata_r <= rdata_nxt;
      mpend_r <= mpend_nxt;
      mval_r <= mval_nxt;
    end

  // Beats per access
  always_comb
  begin
    acc_bytes = 5'h10;
    if (!acc_cacheable && acc_size != 2'h3)
      acc_bytes = 5'(1 << acc_size);
    nbeats = (acc_bytes <= BPW) ? 4'h1 : 4'(acc_bytes / BPW);
    ibeat = (state_r == ST_CMD || state_r == ST_GAP) ? beat_r + 4'h1
      : 4'h0;
    ilast = ibeat == nbeats - 4'h1;
    apw = {1'b0, wait_r[7:6]} + {1'b0, wait_r[1:0]};
  end

  // Command sequencer
  always_comb
  begin
    state_nxt = state_r;
    job_nxt = job_r;
    wcnt_nxt = wcnt_r;
    left_nxt = left_r;
    beat_nxt = beat_r;
    last_nxt = last_r;
    cmd_nxt = `SBR_CMD_NOP;
    cke_nxt = sd_cke_r;
    ba_nxt = sd_ba_r;
    addr_nxt = sd_addr_r;
    dqm_nxt = sd_dqm_r;
    dout_nxt = sd_dq_out_r;
    oe_nxt = 1'b0;
    ack_nxt = pv_r[0] && pl_r[0];
    {go_cmd, go_open, go_all_bank_close_cmd, post_all_bank_close_cmd, go_ref} = 5'h00;
    {rd_issue, bt_set, bt_close, bt_close_all} = 4'h0;
    ref_take = 1'b0;
    mtake = 1'b0;
    case (state_r)
      ST_IDLE:
        if (mpend_r)
        begin
          job_nxt = JOB_INIT;
          left_nxt = `SBR_INIT_REFS;
          mtake = 1'b1;
          go_all_bank_close_cmd = 1'b1;
        end
        else if (self_want)
        begin
          job_nxt = JOB_SELF;
          left_nxt = 4'h0;
          go_all_bank_close_cmd = 1'b1;
        end
        else if (lnk.ref_pend && lnk.ref_ok)
        begin
          job_nxt = JOB_AUTO;
          left_nxt = {1'b0, tctl_r[6:4]} + 4'h1;
          ref_take = 1'b1;
          go_all_bank_close_cmd = 1'b1;
        end
        else if (acc_req)
        begin
          if (lnk.bt_open && hold && lnk.bt_hit)
          begin
            if (!acc_we && cl == 2'h0)
              state_nxt = ST_NOP;
            else
              go_cmd = 1'b1;
          end
          else if (lnk.bt_open)
          begin
            state_nxt = ST_PRE;
            cmd_nxt = `SBR_CMD_PRE;
            ba_nxt = acc_bank;
            addr_nxt[`SBR_AP_BIT] = 1'b0;
            bt_close = 1'b1;
          end
          else
            go_open = 1'b1;
        end
      ST_PRE:
        if (pw2)
        begin
          state_nxt = ST_PWAIT;
          wcnt_nxt = pwc;
        end
        else
          go_open = 1'b1;
      ST_PWAIT:
        if (wcnt_r == 3'h0)
          go_open = 1'b1;
        else
          wcnt_nxt = wcnt_r - 3'h1;
      ST_OPEN, ST_NOP, ST_GAP:
        go_cmd = 1'b1;
      ST_CMD:
        if (!last_r)
        begin
          if (acc_we)
            state_nxt = ST_GAP;
          else
            go_cmd = 1'b1;
        end
        else if (acc_we && sd_addr_r[`SBR_AP_BIT] && apw != 3'h0)
        begin
          state_nxt = ST_APW;
          wcnt_nxt = apw - 3'h1;
        end
        else
          state_nxt = acc_we ? ST_IDLE : ST_RDW;
      ST_RDW:
        if (acc_ack_r)
        begin
          if (sd_addr_r[`SBR_AP_BIT] && wait_r[1:0] != 2'h0)
          begin
            state_nxt = ST_APW;
            wcnt_nxt = {1'b0, wait_r[1:0]} - 3'h1;
          end
          else
            state_nxt = ST_IDLE;
        end
      ST_APW:
        if (wcnt_r == 3'h0)
          state_nxt = ST_IDLE;
        else
          wcnt_nxt = wcnt_r - 3'h1;
      ST_ALL_BANK_CLOSE_CMD:
        if (pw2)
        begin
          state_nxt = ST_PALLW;
          wcnt_nxt = pwc;
        end
        else
          post_all_bank_close_cmd = 1'b1;
      ST_PALLW:
        if (wcnt_r == 3'h0)
          post_all_bank_close_cmd = 1'b1;
        else
          wcnt_nxt = wcnt_r - 3'h1;
      ST_REF:
      begin
        state_nxt = ST_RECW;
        wcnt_nxt = {1'b0, wait_r[3:2]};
      end
      ST_RECW:
        if (wcnt_r != 3'h0)
          wcnt_nxt = wcnt_r - 3'h1;
        else if (left_r != 4'h0)
          go_ref = 1'b1;
        else if (job_r == JOB_INIT)
        begin
          state_nxt = ST_MRS;
          cmd_nxt = `SBR_CMD_MRS;
          ba_nxt = '0;
          addr_nxt = RW'(mval_r);
        end
        else
          state_nxt = ST_IDLE;
      ST_SELF:
        if (!self_want)
        begin
          cke_nxt = 1'b1;
          state_nxt = ST_RECW;
          wcnt_nxt = {1'b0, wait_r[3:2]};
        end
      ST_MRS:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (go_all_bank_close_cmd)
    begin
      state_nxt = ST_ALL_BANK_CLOSE_CMD;
      cmd_nxt = `SBR_CMD_PRE;
      addr_nxt[`SBR_AP_BIT] = 1'b1;
      bt_close_all = 1'b1;
    end
    if (post_all_bank_close_cmd && job_r == JOB_SELF)
    begin
      state_nxt = ST_SELF;
      cmd_nxt = `SBR_CMD_REF;
      cke_nxt = 1'b0;
    end
    else if (post_all_bank_close_cmd)
      go_ref = 1'b1;
    if (go_ref)
    begin
      state_nxt = ST_REF;
      cmd_nxt = `SBR_CMD_REF;
      left_nxt = left_r - 4'h1;
    end
    if (go_open)
    begin
      state_nxt = ST_OPEN;
      cmd_nxt = `SBR_CMD_ACT;
      ba_nxt = acc_bank;
      addr_nxt = acc_row;
      bt_set = hold;
    end
    if (go_cmd)
    begin
      state_nxt = ST_CMD;
      cmd_nxt = acc_we ? `SBR_CMD_WR : `SBR_CMD_RD;
      ba_nxt = acc_bank;
      addr_nxt = RW'(acc_col + CW'(ibeat));
      addr_nxt[`SBR_AP_BIT] = !hold && ilast;
      beat_nxt = ibeat;
      last_nxt = ilast;
      dqm_nxt = ~acc_be;
      dout_nxt = acc_wdata;
      oe_nxt = acc_we;
      rd_issue = !acc_we;
      ack_nxt = ack_nxt || (acc_we && ilast);
    end
  end
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      job_r <= JOB_AUTO;
      wcnt_r <= 3'h0;
      left_r <= 4'h0;
      beat_r <= 4'h0;
      last_r <= 1'b0;
      sd_cmd_n_r <= `SBR_CMD_NOP;
      sd_cke_r <= 1'b1;
      sd_ba_r <= '0;
      sd_addr_r <= '0;
      sd_dqm_r <= '1;
      sd_dq_out_r <= '0;
      sd_dq_oe_r <= 1'b0;
      acc_ack_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      job_r <= job_nxt;
      wcnt_r <= wcnt_nxt;
      left_r <= left_nxt;
      beat_r <= beat_nxt;
      last_r <= last_nxt;
      sd_cmd_n_r <= cmd_nxt;
      sd_cke_r <= cke_nxt;
      sd_ba_r <= ba_nxt;
      sd_addr_r <= addr_nxt;
      sd_dqm_r <= dqm_nxt;
      sd_dq_out_r <= dout_nxt;
      sd_dq_oe_r <= oe_nxt;
      acc_ack_r <= ack_nxt;
    end

  // Read data latch, delayed by the latency setting
  always_comb
  begin
    pv_nxt = pv_r >> 1;
    pl_nxt = pl_r >> 1;
    if (rd_issue)
    begin
      pv_nxt[cl] = 1'b1;
      pl_nxt[cl] = ilast;
    end
    rv_nxt = pv_r[0];
    rdat_nxt = pv_r[0] ? sd_dq_in : acc_rdata_r;
  end
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      pv_r <= 4'h0;
      pl_r <= 4'h0;
      acc_rvalid_r <= 1'b0;
      acc_rdata_r <= '0;
    end
    else
    begin
      pv_r <= pv_nxt;
      pl_r <= pl_nxt;
      acc_rvalid_r <= rv_nxt;
      acc_rdata_r <= rdat_nxt;
    end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  single_write_a: assert property (
    go_cmd && acc_we && nbeats == 4'h1 |=> acc_ack_r ##1 state_r != ST_CMD)
    else $error("single write not one command");
  hold_plain_a: assert property (
    state_r == ST_CMD && hold |-> !sd_addr_r[`SBR_AP_BIT])
    else $error("auto close used in row hold");
  miss_seq_a: assert property (
    state_r == ST_PRE |-> sd_cmd_n_r == `SBR_CMD_PRE
      ##[1:3] sd_cmd_n_r == `SBR_CMD_ACT)
    else $error("row miss sequence broken");
  apw_quiet_a: assert property (
    state_r == ST_APW |-> sd_cmd_n_r == `SBR_CMD_NOP)
    else $error("command during write recovery");
  cl1_idle_a: assert property (
    state_r == ST_NOP |-> cl == 2'h0 ##1 sd_cmd_n_r == `SBR_CMD_RD)
    else $error("idle cycle misplaced");
  close_wait_a: assert property (
    state_r == ST_ALL_BANK_CLOSE_CMD && pw2 |=> state_r == ST_PALLW)
    else $error("close wait cycle missing");
  self_quiet_a: assert property (
    state_r == ST_SELF |-> !sd_cke_r && !sd_dq_oe_r)
    else $error("access during self refresh");
  init_load_a: assert property (
    state_r == ST_MRS |-> sd_cmd_n_r == `SBR_CMD_MRS
      ##1 sd_cmd_n_r == `SBR_CMD_NOP)
    else $error("mode load not followed by idle");
  self_cv: cover property (state_r == ST_SELF ##1 state_r == ST_RECW);
  init_cv: cover property (state_r == ST_MRS);
  miss_cv: cover property (state_r == ST_PRE);
  hit_cv: cover property (state_r == ST_NOP ##1 state_r == ST_CMD);
endmodule

//--- tb/sbr_sdram_model.sv
// Behavioural SDRAM data array on the controller's memory pins
`timescale 1ns/10ps
module sbr_sdram_model
(
  // Clock
  input wire logic mclk,
  // Pins from the controller
  input wire logic [3:0] cmd_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic [31:0] dq_out,
  // Read latency in cycles minus one, as programmed in the controller
  input wire logic [1:0] lat,
  // Read data to the controller
  output logic [31:0] dq_in
);
  logic [31:0] mem [0:1023];
  logic [31:0] last = 32'h0;
  logic [9:0] idx;
  logic [31:0] pd [0:2];
  logic [2:0] pv = 3'h0;
  assign idx = {ba, addr[7:0]};
  // Released bus shows a changing pattern, never the old word
  assign dq_in = (cmd_n == 4'h5 && lat == 2'h0) ? mem[idx]
    : (lat != 2'h0 && pv[lat - 2'h1]) ? pd[lat - 2'h1] : ~last;
  always @(posedge mclk)
  begin
    last <= dq_in;
    pv <= {pv[1:0], cmd_n == 4'h5};
    pd[0] <= mem[idx];
    pd[1] <= pd[0];
    pd[2] <= pd[1];
    if (cmd_n == 4'h4)
      mem[idx] <= dq_out;
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the SDRAM controller
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acc_req = 1'b0;
  logic acc_we = 1'b0;
  logic acc_cacheable = 1'b0;
  logic [1:0] acc_size = 2'h2;
  logic [1:0] acc_bank = 2'h0;
  logic [12:0] acc_row = 13'h0;
  logic [9:0] acc_col = 10'h005;
  logic [31:0] acc_wdata = 32'h0;
  logic [3:0] acc_be = 4'hF;
  logic [31:0] reg_rdata_r, acc_rdata_r, sd_dq_out_r, sd_dq_in;
  logic acc_ack_r, acc_rvalid_r, sd_cke_r, sd_dq_oe_r;
  logic [3:0] sd_cmd_n_r, sd_dqm_r;
  logic [1:0] sd_ba_r;
  logic [12:0] sd_addr_r, mrs_addr;
  logic [1:0] lat = 2'h0;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] log_q [$];
  logic [7:0] exp_q [$];
  localparam logic [31:0] RB = 32'hF8FC0000;

  always #20 mclk = ~mclk;

  sbr_ctrl dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .acc_req, .acc_we, .acc_cacheable, .acc_size,
    .acc_bank, .acc_row, .acc_col, .acc_wdata, .acc_be, .acc_ack_r,
    .acc_rvalid_r, .acc_rdata_r, .sd_cmd_n_r, .sd_cke_r, .sd_ba_r,
    .sd_addr_r, .sd_dqm_r, .sd_dq_out_r, .sd_dq_oe_r, .sd_dq_in);

  sbr_sdram_model sdram (.mclk, .cmd_n(sd_cmd_n_r), .ba(sd_ba_r),
    .addr(sd_addr_r), .dq_out(sd_dq_out_r), .lat(lat), .dq_in(sd_dq_in));

  // Log of issued commands: {self entry, close all or auto close, command}
  always @(posedge mclk)
    if (nrst === 1'b1 && sd_cmd_n_r !== 4'h7)
    begin
      log_q.push_back({2'h0, ~sd_cke_r,
        sd_addr_r[10] & (sd_cmd_n_r inside {4'h2, 4'h4, 4'h5}),
        sd_cmd_n_r});
      if (sd_cmd_n_r == 4'h0)
        mrs_addr <= sd_addr_r;
    end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_log;
    cmp(log_q.size(), exp_q.size());
    foreach (exp_q[i])
      cmp(log_q[i], exp_q[i]);
    log_q = {};
    exp_q = {};
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp(reg_rdata_r, e);
  endtask

  // Single word access; a read expects d back
  task acc(input logic we, input logic [1:0] b, input logic [12:0] r,
    input logic [31:0] d);
    int i;
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_we <= we;
    acc_bank <= b;
    acc_row <= r;
    acc_wdata <= d;
    i = 0;
    do
    begin
      @(negedge mclk);
      i++;
    end
    while (acc_ack_r !== 1'b1 && i < 60);
    cmp(acc_ack_r, 1'b1);
    if (!we)
    begin
      cmp(acc_rdata_r, d);
      cmp(acc_rvalid_r, 1'b1);
    end
    else
    begin
      cmp(sd_dq_oe_r, 1'b1);
      cmp(sd_dq_out_r, d);
    end
    @(posedge mclk);
    acc_req <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_count++;
    stop_test;
  end

  initial
  begin
    int nref;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    cmp(sd_cmd_n_r, 4'h7);
    cmp(sd_cke_r, 1'b1);
    cmp(sd_dqm_r, 4'hF);
    rd(RB, 32'h0);
    wr(RB + 32'h10, 32'h01);
    rd(RB + 32'h10, 32'h01);
    rd(RB + 32'h40, 32'h0);
    acc(1'b1, 2'h0, 13'h5, 32'hA5A5A5A5);
    exp_q = {8'h03, 8'h14};
    chk_log;
    wr(RB, 32'h1);
    acc(1'b1, 2'h0, 13'h5, 32'h11);
    acc(1'b0, 2'h0, 13'h5, 32'h11);
    exp_q = {8'h03, 8'h04, 8'h05};
    chk_log;
    acc(1'b1, 2'h1, 13'h7, 32'h22);
    acc(1'b1, 2'h0, 13'h5, 32'h33);
    acc(1'b0, 2'h1, 13'h7, 32'h22);
    exp_q = {8'h03, 8'h04, 8'h04, 8'h05};
    chk_log;
    acc(1'b1, 2'h0, 13'h9, 32'h44);
    exp_q = {8'h02, 8'h03, 8'h04};
    chk_log;
    wr(RB + 32'h08, 32'd40);
    wr(RB + 32'h0C, 32'd39);
    wr(RB, 32'h5);
    wr(RB + 32'h04, 32'h11);
    repeat (40) @(posedge mclk);
    wr(RB, 32'h1);
    nref = 0;
    foreach (log_q[i])
      if (log_q[i] == 8'h01)
        nref++;
    cmp(nref, 2);
    cmp(log_q[0], 8'h12);
    log_q = {};
    acc(1'b1, 2'h0, 13'h9, 32'h55);
    exp_q = {8'h03, 8'h04};
    chk_log;
    wr(RB + 32'h10, 32'h11);
    lat <= 2'h1;
    acc_cacheable <= 1'b1;
    acc(1'b1, 2'h0, 13'h9, 32'h66);
    acc_cacheable <= 1'b0;
    acc(1'b0, 2'h0, 13'h9, 32'h66);
    exp_q = {8'h04, 8'h04, 8'h04, 8'h04, 8'h05};
    chk_log;
    wr(RB + 32'h10, 32'h02);
    lat <= 2'h0;
    for (int k = 0; k < 2; k++)
    begin
      wr(RB, 32'h6);
      repeat (10) @(posedge mclk);
      exp_q = {8'h12, 8'h21};
      chk_log;
      cmp(sd_cke_r, 1'b0);
      rd(RB + 32'h14, 32'h5);
      @(posedge mclk);
      if (k == 0)
        wr(RB, 32'h0);
      else
        nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      cmp(sd_cke_r, 1'b1);
      log_q = {};
    end
    wr(RB + 32'h10, 32'h01);
    wr(32'hF8FD5022, 32'hFFFFFFFF);
    repeat (40) @(posedge mclk);
    exp_q = {8'h12, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
      8'h01, 8'h00};
    chk_log;
    cmp(mrs_addr, 13'h0022);
    stop_test;
  end
endmodule
